// file: pkg/fpbw_pkg.sv
// constants and types of the flash page buffer writer
// assumes a 16-bit byte address space of the core and an axi4-lite master
package fpbw_pkg;

  // ******************************************************************
  // memory map of the core address space
  // ******************************************************************
  localparam logic [15:0] FLASH_BASE  = 16'h4000;
  localparam logic [15:0] FLASH_LAST  = 16'hffff;
  localparam int          FLASH_BYTES = 49152;
  localparam int          PAGE_BYTES  = 128;
  localparam int          PAGE_COUNT  = 384;
  localparam logic [15:0] BOOT_BASE   = 16'h3800;
  localparam logic [15:0] BOOT_LAST   = 16'h3fff;
  localparam int          BOOT_BYTES  = 2048;
  localparam logic [7:0]  ERASED_BYTE = 8'hff;

  // ******************************************************************
  // write protect key and timing
  // ******************************************************************
  localparam logic [3:0] WP_ENABLE     = 4'h3;
  localparam logic [3:0] WP_DISABLE    = 4'hc;
  localparam int         WARMUP_CYCLES = 1024;
  localparam int         PROG_TIME_US  = 4000;
  localparam int         OSC_KHZ       = 1000;
  localparam int         PROG_OSC_TICKS = PROG_TIME_US * OSC_KHZ / 1000;
  localparam int         CELL_OSC_TICKS = 4;

  // ******************************************************************
  // register offsets (byte addresses)
  // ******************************************************************
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STAT     = 8'h04;
  localparam logic [7:0] OFS_EMU      = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h10;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h14;

  // ******************************************************************
  // field positions and reset values
  // ******************************************************************
  localparam int CTRL_KEY_LSB  = 0;
  localparam int CTRL_PWR_BIT  = 4;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RDY_BIT  = 1;
  localparam int STAT_EMPTY_BIT = 2;
  localparam int EMU_W         = 3;
  localparam int IRQ_W         = 4;
  localparam int IRQ_DONE_BIT  = 0;
  localparam int IRQ_SWI_BIT   = 1;
  localparam int IRQ_REFUSE_BIT = 2;
  localparam int IRQ_ABORT_BIT = 3;
  localparam logic [EMU_W-1:0] EMU_RST    = 3'h0;
  localparam logic [IRQ_W-1:0] IRQ_EN_RST = 4'h0;
  localparam logic [1:0] AXI_OKAY   = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;

  // ******************************************************************
  // types
  // ******************************************************************
  typedef struct packed {
    logic        valid;
    logic        we;
    logic        fetch;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } fpbw_cpu_req_t;

  typedef struct packed {
    logic       pwr_req;
    logic [3:0] key;
  } fpbw_ctrl_t;

  localparam fpbw_ctrl_t CTRL_RST = '{pwr_req: 1'b0, key: WP_DISABLE};

  typedef enum logic [1:0] {
    FPBW_IDLE   = 2'b00,
    FPBW_ERASE  = 2'b01,
    FPBW_PROG   = 2'b10,
    FPBW_COMMIT = 2'b11
  } fpbw_state_t;

endpackage

// file: hw/fpbw_flash_array.sv
// page-wide flash cell array: one page written per cycle, bytes read
// assumes the caller keeps page indices below the page count
module fpbw_flash_array #(
  parameter int PAGES     = fpbw_pkg::PAGE_COUNT,
  parameter int PAGE_BITS = fpbw_pkg::PAGE_BYTES * 8
) (
  input  wire logic                 aclk,
  input  wire logic                 clk_en,
  input  wire logic                 wr_en,
  input  wire logic [8:0]           wr_page,
  input  wire logic [PAGE_BITS-1:0] wr_data,
  input  wire logic [8:0]           rd_page,
  input  wire logic [6:0]           rd_byte,
  output logic      [7:0]           rd_data
);

  // ******************************************************************
  // storage
  // ******************************************************************
  // whole page per word, so a page program lands in one write
  logic [PAGE_BITS-1:0] mem [PAGES];

  always_ff @(posedge aclk) begin
    if (clk_en && wr_en) begin
      mem[wr_page] <= wr_data;
    end
  end

  // any single byte of any page can be read
  always_comb begin
    rd_data = mem[rd_page][{rd_byte, 3'b000} +: 8];
  end

endmodule

// file: hw/fpbw_top.sv
// flash page buffer writer: staging buffer, page sequencer, core port
// assumes serial_prog_mode comes from mode logic on aclk and that osc_clk
// is the free running dedicated oscillator, unrelated to aclk
//
// Behaviour
// - a 49152-byte array at 4000h..ffffh is read and fetched by the core.
// - the array is 384 pages of 128 bytes and a page is programmed whole.
// - written bytes gather in a 128-byte buffer; the 128th starts a page.
// - every page program erases the page first on its own.
// - program time is per page, about 4 ms, set by cells, not by aclk.
// - program time is counted on the dedicated oscillator.
// - any byte is readable alone although writes go page by page.
// - writes to the flash range act only in serial programming mode.
// - a write counts only when key is 0011, ready is 1 and busy is 0.
// - flash reads and fetches give ffh while busy; fetching ffh gives an swi.
// - the write time emulation register is read/write with no effect.
// - the flash control power can be switched off while unused.
// - a 2-kbyte boot rom sits beside the flash area.
// - the key resets to 1100, 0011 enables writes and 1100 disables.
// - ready rises a warm-up time after the power request goes high.
module fpbw_top #(
  parameter int         PROG_OSC_TICKS = fpbw_pkg::PROG_OSC_TICKS,
  parameter int         CELL_OSC_TICKS = fpbw_pkg::CELL_OSC_TICKS,
  parameter logic [7:0] BOOT_FILL      = 8'h00
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  clk_en,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  serial_prog_mode,
  input  wire logic                  osc_clk,
  input  wire fpbw_pkg::fpbw_cpu_req_t cpu_req,
  output logic [7:0]                 cpu_rdata,
  output logic                       cpu_rvalid,
  output logic                       sw_int,
  output logic                       flash_pwr_en,
  output logic                       irq
);

  localparam int PB = fpbw_pkg::PAGE_BYTES;

  // ******************************************************************
  // declarations
  // ******************************************************************
  fpbw_pkg::fpbw_ctrl_t          ctrl_q;
  logic [fpbw_pkg::EMU_W-1:0]    emu_q;
  logic [fpbw_pkg::IRQ_W-1:0]    irq_stat_q, irq_en_q, irq_set, irq_clr;
  fpbw_pkg::fpbw_state_t         state_q;
  logic [23:0]                   timer_q;
  logic [8:0]                    page_q;
  logic [6:0]                    cnt_q;
  logic [7:0]                    stage_q [PB];
  logic [10:0]                   wu_cnt_q;
  logic                          ready_q;
  logic                          osc_s1_q, osc_s2_q, osc_s3_q;
  logic                          osc_tick;
  logic                          busy, in_flash, in_boot, wr_ok, launch;
  logic                          abort;
  logic [15:0]                   foff;
  logic [7:0]                    arr_rd, rd_d;
  logic                          arr_wr;
  logic [PB*8-1:0]               arr_wdata;
  logic                          aw_got_q, w_got_q, bvalid_q, arready_q;
  logic                          rvalid_q;
  logic [7:0]                    awaddr_q;
  logic [31:0]                   wdata_q, rdata_q, rdata_d;
  logic [3:0]                    wstrb_q;
  logic [1:0]                    bresp_q, rresp_q, rresp_d;
  logic                          wr_fire;
  logic [7:0]                    cpu_rdata_q;
  logic                          cpu_rvalid_q, sw_int_q, irq_q;

  // bytes that leave erased cells untouched cost no cell program time
  function automatic logic [7:0] count_programmed(input logic [PB*8-1:0] p);
    logic [7:0] n;
    n = 8'h00;
    for (int i = 0; i < PB; i++) begin
      if (p[i*8 +: 8] != fpbw_pkg::ERASED_BYTE) begin
        n = n + 8'h01;
      end
    end
    return n;
  endfunction

  // ******************************************************************
  // core address decode
  // ******************************************************************
  assign in_flash = (cpu_req.addr >= fpbw_pkg::FLASH_BASE) &&
                    (cpu_req.addr <= fpbw_pkg::FLASH_LAST);
  assign in_boot  = (cpu_req.addr >= fpbw_pkg::BOOT_BASE) &&
                    (cpu_req.addr <= fpbw_pkg::BOOT_LAST);
  assign foff     = cpu_req.addr - fpbw_pkg::FLASH_BASE;
  assign busy     = (state_q != fpbw_pkg::FPBW_IDLE);
  assign wr_ok    = cpu_req.valid && cpu_req.we && in_flash &&
                    serial_prog_mode &&
                    (ctrl_q.key == fpbw_pkg::WP_ENABLE) && ready_q &&
                    !busy;
  assign launch   = wr_ok && (cnt_q == 7'(PB - 1));
  assign abort    = busy && !ctrl_q.pwr_req;

  // ******************************************************************
  // dedicated oscillator crossing
  // ******************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end else if (clk_en) begin
      osc_s1_q <= osc_clk;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  // needs aclk well above twice the oscillator rate to see every edge
  assign osc_tick = osc_s2_q && !osc_s3_q;

  // ******************************************************************
  // staging buffer and byte counter
  // ******************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q  <= 7'h00;
      page_q <= 9'h000;
    end else if (clk_en) begin
      if (abort || !ctrl_q.pwr_req) begin
        cnt_q <= 7'h00;
      end else if (wr_ok) begin
        cnt_q  <= cnt_q + 7'h01;
        page_q <= foff[15:7];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (clk_en) begin
      if (state_q == fpbw_pkg::FPBW_COMMIT) begin
        for (int i = 0; i < PB; i++) begin
          stage_q[i] <= fpbw_pkg::ERASED_BYTE;
        end
      end else if (wr_ok) begin
        stage_q[foff[6:0]] <= cpu_req.wdata;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < PB; i++) begin
      arr_wdata[i*8 +: 8] = stage_q[i];
    end
  end

  // ******************************************************************
  // page sequencer
  // ******************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= fpbw_pkg::FPBW_IDLE;
      timer_q <= 24'h000000;
    end else if (clk_en) begin
      case (state_q)
        fpbw_pkg::FPBW_IDLE: begin
          if (launch) begin
            state_q <= fpbw_pkg::FPBW_ERASE;
          end
        end
        fpbw_pkg::FPBW_ERASE: begin
          timer_q <= 24'(PROG_OSC_TICKS) + 24'(count_programmed(arr_wdata))
                     * 24'(CELL_OSC_TICKS);
          state_q <= abort ? fpbw_pkg::FPBW_IDLE : fpbw_pkg::FPBW_PROG;
        end
        fpbw_pkg::FPBW_PROG: begin
          if (abort) begin
            state_q <= fpbw_pkg::FPBW_IDLE;
          end else if (osc_tick) begin
            if (timer_q <= 24'h000001) begin
              state_q <= fpbw_pkg::FPBW_COMMIT;
            end
            timer_q <= timer_q - 24'h000001;
          end
        end
        fpbw_pkg::FPBW_COMMIT: begin
          state_q <= fpbw_pkg::FPBW_IDLE;
        end
        default: begin
          state_q <= fpbw_pkg::FPBW_IDLE;
        end
      endcase
    end
  end

  // erase writes all ones, commit writes the staged page
  assign arr_wr = !abort && ((state_q == fpbw_pkg::FPBW_ERASE) ||
                  (state_q == fpbw_pkg::FPBW_COMMIT));

  fpbw_flash_array u_array (
    .aclk    (aclk),
    .clk_en  (clk_en),
    .wr_en   (arr_wr),
    .wr_page (page_q),
    .wr_data ((state_q == fpbw_pkg::FPBW_ERASE) ? {(PB*8){1'b1}}
              : arr_wdata),
    .rd_page (foff[15:7]),
    .rd_byte (foff[6:0]),
    .rd_data (arr_rd)
  );

  // ******************************************************************
  // control power warm-up
  // ******************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wu_cnt_q <= 11'h000;
      ready_q  <= 1'b0;
    end else if (clk_en) begin
      if (!ctrl_q.pwr_req) begin
        wu_cnt_q <= 11'h000;
        ready_q  <= 1'b0;
      end else if (!ready_q) begin
        wu_cnt_q <= wu_cnt_q + 11'h001;
        ready_q  <= (wu_cnt_q == 11'(fpbw_pkg::WARMUP_CYCLES - 1));
      end
    end
  end

  // ******************************************************************
  // core read port
  // ******************************************************************
  always_comb begin
    if (in_flash) begin
      rd_d = busy ? fpbw_pkg::ERASED_BYTE : arr_rd;
    end else if (in_boot) begin
      rd_d = BOOT_FILL;
    end else begin
      rd_d = fpbw_pkg::ERASED_BYTE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_rdata_q  <= 8'h00;
      cpu_rvalid_q <= 1'b0;
      sw_int_q     <= 1'b0;
    end else if (clk_en) begin
      cpu_rvalid_q <= cpu_req.valid && !cpu_req.we;
      sw_int_q     <= cpu_req.valid && !cpu_req.we && cpu_req.fetch &&
                      (rd_d == fpbw_pkg::ERASED_BYTE);
      if (cpu_req.valid && !cpu_req.we) begin
        cpu_rdata_q <= rd_d;
      end
    end
  end

  // ******************************************************************
  // interrupt status
  // ******************************************************************
  always_comb begin
    irq_set = '0;
    irq_set[fpbw_pkg::IRQ_DONE_BIT]   = (state_q == fpbw_pkg::FPBW_COMMIT);
    irq_set[fpbw_pkg::IRQ_SWI_BIT]    = sw_int_q;
    irq_set[fpbw_pkg::IRQ_REFUSE_BIT] = cpu_req.valid && cpu_req.we &&
                                        in_flash && !wr_ok;
    irq_set[fpbw_pkg::IRQ_ABORT_BIT]  = abort;
  end

  assign irq_clr = (wr_fire && (awaddr_q == fpbw_pkg::OFS_IRQ_CLR) &&
                    wstrb_q[0]) ? wdata_q[fpbw_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= '0;
      irq_q      <= 1'b0;
    end else if (clk_en) begin
      // a new event wins over a clear in the same cycle
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
      irq_q      <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_en_q);
    end
  end

  // ******************************************************************
  // axi4-lite write channel
  // ******************************************************************
  assign wr_fire = aw_got_q && w_got_q && !bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q  <= fpbw_pkg::AXI_OKAY;
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h00000000;
      wstrb_q  <= 4'h0;
    end else if (clk_en) begin
      if (s_axi_awvalid && !aw_got_q && !bvalid_q) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_got_q && !bvalid_q) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        bvalid_q <= 1'b1;
        if ((awaddr_q == fpbw_pkg::OFS_CTRL) ||
            (awaddr_q == fpbw_pkg::OFS_EMU) ||
            (awaddr_q == fpbw_pkg::OFS_IRQ_CLR) ||
            (awaddr_q == fpbw_pkg::OFS_IRQ_EN)) begin
          bresp_q <= fpbw_pkg::AXI_OKAY;
        end else begin
          bresp_q <= fpbw_pkg::AXI_SLVERR;
        end
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q   <= fpbw_pkg::CTRL_RST;
      emu_q    <= fpbw_pkg::EMU_RST;
      irq_en_q <= fpbw_pkg::IRQ_EN_RST;
    end else if (clk_en && wr_fire && wstrb_q[0]) begin
      if (awaddr_q == fpbw_pkg::OFS_CTRL) begin
        ctrl_q.key     <= wdata_q[fpbw_pkg::CTRL_KEY_LSB +: 4];
        ctrl_q.pwr_req <= wdata_q[fpbw_pkg::CTRL_PWR_BIT];
      end else if (awaddr_q == fpbw_pkg::OFS_EMU) begin
        emu_q <= wdata_q[fpbw_pkg::EMU_W-1:0];
      end else if (awaddr_q == fpbw_pkg::OFS_IRQ_EN) begin
        irq_en_q <= wdata_q[fpbw_pkg::IRQ_W-1:0];
      end
    end
  end

  // ******************************************************************
  // axi4-lite read channel
  // ******************************************************************
  always_comb begin
    rdata_d = 32'h00000000;
    rresp_d = fpbw_pkg::AXI_OKAY;
    if (s_axi_araddr == fpbw_pkg::OFS_CTRL) begin
      rdata_d[fpbw_pkg::CTRL_KEY_LSB +: 4] = ctrl_q.key;
      rdata_d[fpbw_pkg::CTRL_PWR_BIT]      = ctrl_q.pwr_req;
    end else if (s_axi_araddr == fpbw_pkg::OFS_STAT) begin
      rdata_d[fpbw_pkg::STAT_BUSY_BIT]  = busy;
      rdata_d[fpbw_pkg::STAT_RDY_BIT]   = ready_q;
      rdata_d[fpbw_pkg::STAT_EMPTY_BIT] = (cnt_q == 7'h00) && !busy;
    end else if (s_axi_araddr == fpbw_pkg::OFS_EMU) begin
      rdata_d[fpbw_pkg::EMU_W-1:0] = emu_q;
    end else if (s_axi_araddr == fpbw_pkg::OFS_IRQ_STAT) begin
      rdata_d[fpbw_pkg::IRQ_W-1:0] = irq_stat_q;
    end else if (s_axi_araddr == fpbw_pkg::OFS_IRQ_EN) begin
      rdata_d[fpbw_pkg::IRQ_W-1:0] = irq_en_q;
    end else if (s_axi_araddr == fpbw_pkg::OFS_IRQ_CLR) begin
      rdata_d = 32'h00000000;
    end else begin
      rresp_d = fpbw_pkg::AXI_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= fpbw_pkg::AXI_OKAY;
    end else if (clk_en) begin
      arready_q <= !rvalid_q && !arready_q;
      if (s_axi_arvalid && arready_q) begin
        rvalid_q  <= 1'b1;
        arready_q <= 1'b0;
        rdata_q   <= rdata_d;
        rresp_q   <= rresp_d;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ******************************************************************
  // outputs
  // ******************************************************************
  assign s_axi_awready = !aw_got_q && !bvalid_q;
  assign s_axi_wready  = !w_got_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign cpu_rdata     = cpu_rdata_q;
  assign cpu_rvalid    = cpu_rvalid_q;
  assign sw_int        = sw_int_q;
  assign flash_pwr_en  = ctrl_q.pwr_req;
  assign irq           = irq_q;

endmodule

// file: tb/fpbw_properties.sv
// checker on the core and register ports of the flash page buffer writer
// assumes it is bound into the top and sees only the top's ports
module fpbw_properties (
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire logic                    clk_en,
  input wire fpbw_pkg::fpbw_cpu_req_t cpu_req,
  input wire logic [7:0]              cpu_rdata,
  input wire logic                    cpu_rvalid,
  input wire logic                    sw_int,
  input wire logic                    s_axi_awready,
  input wire logic                    s_axi_wready,
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_bready,
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic                    s_axi_rvalid,
  input wire logic                    s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // core port and register bus
  // ****************
  // an edge with the enable low moves no flop, so it is not judged
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn || !clk_en);
  property p_rd_ans; cpu_req.valid && !cpu_req.we |=> cpu_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read not answered");
  property p_wr_quiet; cpu_req.valid && cpu_req.we |=> !cpu_rvalid; endproperty
  a_wr_quiet: assert property (p_wr_quiet)
    else $error("write answered");
  property p_swi_ff; sw_int |-> cpu_rvalid && cpu_rdata == 8'hff; endproperty
  a_swi_ff: assert property (p_swi_ff)
    else $error("swi without ff");
  property p_ff_swi;
    cpu_req.valid && !cpu_req.we && cpu_req.fetch ##1 cpu_rdata == 8'hff
      |-> sw_int;
  endproperty
  a_ff_swi: assert property (p_ff_swi)
    else $error("ff fetch no swi");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("bvalid dropped");
  property p_b_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_b_block: assert property (p_b_block)
    else $error("write taken early");
  property p_r_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_r_ans: assert property (p_r_ans)
    else $error("read late");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid;
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("rvalid dropped");
endmodule

bind fpbw_top fpbw_properties i_fpbw_properties (.aclk, .aresetn, .clk_en,
  .cpu_req, .cpu_rdata, .cpu_rvalid, .sw_int, .s_axi_awready, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready);

// file: tb/fpbw_core_model.sv
// behavioural processor core: one byte access at a time on cpu_req
// assumes the bench calls acc from one process only
module fpbw_core_model (
  input wire logic                aclk,
  output fpbw_pkg::fpbw_cpu_req_t cpu_req,
  input wire logic [7:0]          cpu_rdata,
  input wire logic                sw_int
);
  timeunit 1ns;
  timeprecision 1ps;
  initial cpu_req = '0;
  // ****************
  // access task
  // ****************
  // idle lines are flipped so a stale address never passes for a live one
  task automatic acc(input logic w, f, input logic [15:0] a,
                     input logic [7:0] dt, output logic [7:0] q,
                     output logic s);
    @(posedge aclk);
    cpu_req <= '{1'b1, w, f, a, dt};
    @(posedge aclk);
    cpu_req <= '{1'b0, 1'b0, 1'b0, ~a, ~dt};
    @(posedge aclk);
    q = cpu_rdata;
    s = sw_int;
  endtask
endmodule

// file: tb/tb.sv
// self-checking bench of the flash page buffer writer
// assumes the core model owns cpu_req and this module is the axi master
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 0, aresetn = 0, spm = 0, osc = 0, ce = 1;
  logic [7:0]  awaddr = 0, araddr = 0, q;
  logic [31:0] wdata = 0, rdata, d;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, irq, pwr, s, swi;
  logic [1:0]  bresp, rresp, r;
  logic [7:0]  crd, img[$];
  fpbw_pkg::fpbw_cpu_req_t req;
  int          n_fail = 0, total_checks = 0, cyc = 0, n, pg;
  time         t0;
  always #5 aclk = ~aclk;
  always #30 osc = ~osc;
  fpbw_top #(.PROG_OSC_TICKS(5), .CELL_OSC_TICKS(1)) i_fpbw_top (
    .aclk, .aresetn, .clk_en(ce), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .serial_prog_mode(spm), .osc_clk(osc),
    .cpu_req(req), .cpu_rdata(crd), .cpu_rvalid(), .sw_int(swi),
    .flash_pwr_en(pwr), .irq);
  fpbw_core_model u_core (.aclk, .cpu_req(req), .cpu_rdata(crd), .sw_int(swi));
  // ****************
  // bus tasks and checks
  // ****************
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    fork
      begin @(posedge aclk iff awready); awvalid <= 0; end
      begin @(posedge aclk iff wready); wvalid <= 0; end
    join
    // ready comes late on purpose, so a held response is exercised
    @(posedge aclk iff bvalid);
    bready <= 1;
    @(posedge aclk iff bvalid);
    r = bresp;
    bready <= 0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    @(posedge aclk iff arready);
    arvalid <= 0;
    @(posedge aclk iff rvalid);
    rready <= 1;
    @(posedge aclk iff rvalid);
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // run length is bounded: warm-up plus one page stays far below this
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      test_done;
    end
  end
  // ****************
  // main sequence
  // ****************
  initial begin
    n = $urandom(52176);
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    axr(8'h00); chk("ctrl_rst", d, 32'hc);
    pg = $urandom_range(7);
    axw(8'h08, pg); chk("wr_okay", r, 2'b00);
    axr(8'h08); chk("emu", d, pg);
    axw(8'h44, 1); chk("wr_slverr", r, 2'b10);
    axr(8'h44); chk("unmapped", r, 2'b10);
    u_core.acc(0, 1, 16'h3800, 8'h0, q, s); chk("boot", {s, q}, 0);
    $display("registers done");
    axw(8'h00, 32'h1c);
    t0 = $time;
    n = 0;
    do begin axr(8'h04); n++; end while (d[1] !== 1'b1 && n < 600);
    chk("warmup", 32'(($time - t0) >= 10000), 1);
    chk("ready", d[1], 1);
    chk("pwr", pwr, 1);
    $display("warm-up done");
    // key shut with mode on, then key open with mode off; irq masked in 2nd
    for (int i = 0; i < 2; i++) begin
      spm <= (i == 0);
      axw(8'h00, i ? 32'h13 : 32'h1c);
      axw(8'h14, i ? 0 : 4);
      u_core.acc(1, 0, 16'h4000, 8'h5a, q, s);
      axr(8'h0c); chk("refused", d, 4);
      chk("irq", irq, i == 0);
      axw(8'h10, 4); axr(8'h0c); chk("clr", d, 0);
      chk("irq_clr", irq, 0);
    end
    $display("refusals done");
    spm <= 1;
    pg = $urandom_range(383);
    for (int i = 0; i < 128; i++) begin
      img.push_back(8'($urandom));
      u_core.acc(1, 0, 16'(16'h4000 + pg * 128 + i), img[i], q, s);
    end
    u_core.acc(0, 1, 16'(16'h4000 + pg * 128), 8'h0, q, s);
    chk("busy_rd", {s, q}, 9'h1ff);
    // enable low freezes the core port: the boot read must not land
    ce <= 0;
    u_core.acc(0, 0, 16'h3800, 8'h0, q, s); chk("frozen", {s, q}, 9'h0ff);
    ce <= 1;
    n = 0;
    do begin axr(8'h04); n++; end while (d[0] !== 1'b0 && n < 600);
    chk("idle", d[2:0], 3'b110);
    axr(8'h0c); chk("done", d, 3);
    foreach (img[i]) begin
      u_core.acc(0, 0, 16'(16'h4000 + pg * 128 + i), 8'h0, q, s);
      chk("byte", q, img[i]);
    end
    $display("page done");
    test_done;
  end
endmodule
